//--- shared/adcc_pkg.sv
// Constants, register map and state types of the converter control block.
// Assumes a 40 MHz core clock and an 8-bit special function register port.
package adcc_pkg;

  // ---------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS       = 25;
  localparam int MIN_CONV_PERIOD_NS  = 10000;  // 100 ksps ceiling
  localparam int MIN_CONV_CYCLES     =
    (MIN_CONV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_W               = $clog2(MIN_CONV_CYCLES);
  localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(MIN_CONV_CYCLES - 1);
  localparam int RES_BITS            = 10;
  localparam logic [3:0] CONV_LAST_TICK  = 4'hF;  // 16 SAR clocks per conversion
  localparam logic [3:0] DECIDE_TICKS    = 4'hA;  // bit decisions per conversion
  localparam logic [1:0] TRACK_LAST_TICK = 2'h2;  // 3 SAR clocks of tracking

  // ---------------------------------------------------------------------
  // Register addresses and reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_PAIR_CFG = 8'hBA;
  localparam logic [7:0] ADDR_CHAN_SEL = 8'hBB;
  localparam logic [7:0] ADDR_CONFIG   = 8'hBC;
  localparam logic [7:0] ADDR_RES_LOW  = 8'hBE;
  localparam logic [7:0] ADDR_RES_HIGH = 8'hBF;
  localparam logic [7:0] ADDR_CONTROL  = 8'hE8;
  localparam logic [3:0] RST_PAIR_CFG  = 4'h0;
  localparam logic [3:0] RST_CHAN_SEL  = 4'h0;
  localparam logic [2:0] RST_PERIOD    = 3'h3;
  localparam logic [2:0] RST_GAIN      = 3'h0;   // unity gain

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int CTL_EN      = 7;
  localparam int CTL_TM      = 6;
  localparam int CTL_INT     = 5;
  localparam int CTL_BUSY    = 4;
  localparam int CTL_STM_LO  = 2;
  localparam int CTL_LJST    = 0;
  localparam int CFG_SC_LO   = 5;
  localparam int CFG_GAIN_LO = 0;
  localparam int CHAN_TEMP   = 3;
  localparam logic [3:0] MUX_TEMP = 4'h8;

  // ---------------------------------------------------------------------
  // Start modes and sequencer states
  // ---------------------------------------------------------------------
  localparam logic [1:0] STM_SOFT = 2'h0;
  localparam logic [1:0] STM_T3   = 2'h1;
  localparam logic [1:0] STM_EXT  = 2'h2;
  localparam logic [1:0] STM_T2   = 2'h3;

  typedef enum logic [1:0] {
    ADCC_IDLE  = 2'b00,
    ADCC_TRACK = 2'b01,
    ADCC_CONV  = 2'b11
  } adcc_state_t;

endpackage

//--- verilog/adcc_sar_clk_div.sv
// SAR clock divider: one-cycle tick every 1, 2, 4, 8 or 16 core clocks.
// Assumes clear is held while the sequencer is idle so phases start fresh.
`timescale 1ns/1ps
module adcc_sar_clk_div
  import adcc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       clear,
  input  wire logic [2:0] period_sel,
  output logic            tick
);

  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [3:0] limit;

  // ---------------------------------------------------------------------
  // Divide ratio and count
  // ---------------------------------------------------------------------
  always_comb begin
    limit = period_sel[2] ? 4'hF : 4'((4'h1 << period_sel[1:0]) - 4'h1);
    tick  = !clear && (cnt == limit);
    if (clear || tick) begin
      next_cnt = 4'h0;
    end else begin
      next_cnt = 4'(cnt + 4'h1);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 4'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule

//--- verilog/adcc_conversion_control.sv
// Conversion control for a 10-bit successive-approximation converter.
// Assumes timer overflows and comparator are on core_clk; pin is async.
// Function
// - Converter, track-and-hold and gain run only while enable is 1.
// - Nine channels: eight external inputs plus the temperature sensor.
// - After reset every input is single-ended, no pair differential.
// - Three-bit gain field selects 0.5, 1, 2, 4, 8 or 16.
// - Gain field resets to unity.
// - SAR clock is core clock divided by 1, 2, 4, 8 or 16.
// - Start mode picks software, timer 3, external edge or timer 2.
// - Busy reads 1 through a conversion, 0 after completion.
// - Busy falling sets done flag; interrupt only when enabled.
// - Result lands in high/low registers, justified by justify bit.
// - Track mode 0: track continuously except during conversion.
// - Track mode 1, non-external: track 3 SAR clocks from trigger.
// - Track mode 1, external: track only while start input is low.
// - Tracking stops while the chip is in standby or sleep.
// - Undivided clock: one conversion takes 16 core clocks.
// - Conversions never start faster than 100 ksps.
// - Pair configuration may change between conversions freely.
// - Pair bit 1 makes even/odd inputs one differential channel.
// - Differential results are two's complement.
// - Channel select with top bit set picks the temperature sensor.
`timescale 1ns/1ps
module adcc_conversion_control
  import adcc_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire logic [7:0]          sfr_addr,
  input  wire logic                sfr_wr,
  input  wire logic                sfr_rd,
  input  wire logic [7:0]          sfr_wdata,
  output logic      [7:0]          sfr_rdata,
  input  wire logic                timer3_overflow,
  input  wire logic                timer2_overflow,
  input  wire logic                external_convert_start,
  input  wire logic                chip_low_power,
  input  wire logic                irq_enable,
  input  wire logic                sar_cmp,
  output logic                     conv_irq,
  output logic                     analog_enable,
  output logic                     track_enable,
  output logic      [3:0]          mux_channel,
  output logic                     mux_differential,
  output logic      [2:0]          gain_select,
  output logic      [RES_BITS-1:0] sar_trial
);

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  logic                converter_enable, next_converter_enable;
  logic                track_mode_select, next_track_mode_select;
  logic                conversion_done_flag, next_conversion_done_flag;
  logic [1:0]          start_mode, next_start_mode;
  logic                result_left_justify, next_result_left_justify;
  logic [3:0]          pair_config_reg, next_pair_config_reg;
  logic [3:0]          channel_select_field, next_channel_select_field;
  logic [2:0]          clock_period_field, next_clock_period_field;
  logic [2:0]          gain_select_field, next_gain_select_field;
  logic [7:0]          next_sfr_rdata;
  logic                next_conv_irq;
  adcc_state_t         state, next_state;
  logic [1:0]          track_cnt, next_track_cnt;
  logic [3:0]          tick_cnt, next_tick_cnt;
  logic [GAP_W-1:0]    gap_cnt, next_gap_cnt;
  logic [RES_BITS-1:0] next_sar_trial;
  logic [RES_BITS-1:0] result_raw, next_result_raw;
  logic                result_diff, next_result_diff;
  logic                conv_diff, next_conv_diff;
  logic                next_analog_enable, next_track_enable, next_mux_differential;
  logic [3:0]          next_mux_channel;
  logic [2:0]          next_gain_select;
  logic                ext_meta, ext_sync, ext_prev;
  logic                sar_tick, busy, trigger, start_ok, conv_done, wr_ctl;
  logic                live_diff;
  logic [3:0]          bit_idx;
  logic [15:0]         data_word;

  // ---------------------------------------------------------------------
  // External start pin synchroniser and edge detect
  // ---------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= external_convert_start;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // SAR clock from the core clock, restarted at each phase
  adcc_sar_clk_div u_div (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .clear      (state == ADCC_IDLE),
    .period_sel (clock_period_field),
    .tick       (sar_tick)
  );

  // ---------------------------------------------------------------------
  // Trigger selection and start qualification
  // ---------------------------------------------------------------------
  always_comb begin
    wr_ctl = sfr_wr && (sfr_addr == ADDR_CONTROL);
    unique case (start_mode)
      STM_SOFT: trigger = wr_ctl && sfr_wdata[CTL_BUSY];
      STM_T3:   trigger = timer3_overflow;
      STM_EXT:  trigger = ext_sync && !ext_prev;
      STM_T2:   trigger = timer2_overflow;
    endcase
    start_ok  = converter_enable && (state == ADCC_IDLE) && (gap_cnt == '0) && trigger;
    busy      = (state != ADCC_IDLE);
    conv_done = (state == ADCC_CONV) && sar_tick && (tick_cnt == CONV_LAST_TICK);
    live_diff = !channel_select_field[CHAN_TEMP] &&
                pair_config_reg[channel_select_field[2:1]];
    bit_idx   = 4'(4'(RES_BITS - 1) - tick_cnt);
  end

  // ---------------------------------------------------------------------
  // Sequencer: idle, tracking window, bit decisions
  // ---------------------------------------------------------------------
  always_comb begin
    next_state       = state;
    next_track_cnt   = track_cnt;
    next_tick_cnt    = tick_cnt;
    next_sar_trial   = sar_trial;
    next_result_raw  = result_raw;
    next_result_diff = result_diff;
    next_conv_diff   = conv_diff;
    next_gap_cnt     = (gap_cnt == '0) ? gap_cnt : GAP_W'(gap_cnt - 1'b1);
    unique case (state)
      ADCC_IDLE: begin
        if (start_ok) begin
          next_gap_cnt   = GAP_LOAD;
          next_conv_diff = live_diff;
          next_track_cnt = 2'h0;
          next_tick_cnt  = 4'h0;
          next_sar_trial = RES_BITS'(1) << (RES_BITS - 1);
          if (track_mode_select && (start_mode != STM_EXT)) begin
            next_state = ADCC_TRACK;
          end else begin
            next_state = ADCC_CONV;
          end
        end
      end
      ADCC_TRACK: begin
        if (sar_tick) begin
          next_track_cnt = 2'(track_cnt + 2'h1);
          if (track_cnt == TRACK_LAST_TICK) begin
            next_state = ADCC_CONV;
          end
        end
      end
      ADCC_CONV: begin
        if (sar_tick) begin
          next_tick_cnt = 4'(tick_cnt + 4'h1);
          if (tick_cnt < DECIDE_TICKS) begin
            next_sar_trial[bit_idx] = sar_cmp;
            if (bit_idx != 4'h0) begin
              next_sar_trial[4'(bit_idx - 4'h1)] = 1'b1;
            end
          end
          if (conv_done) begin
            next_state       = ADCC_IDLE;
            next_result_diff = conv_diff;
            // Offset binary to two's complement for differential pairs
            next_result_raw  = {sar_trial[RES_BITS-1] ^ conv_diff,
                                sar_trial[RES_BITS-2:0]};
          end
        end
      end
      default: next_state = ADCC_IDLE;
    endcase
    if (!converter_enable) begin
      next_state = ADCC_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state       <= ADCC_IDLE;
      track_cnt   <= 2'h0;
      tick_cnt    <= 4'h0;
      sar_trial   <= '0;
      result_raw  <= '0;
      result_diff <= 1'b0;
      conv_diff   <= 1'b0;
      gap_cnt     <= '0;
    end else begin
      state       <= next_state;
      track_cnt   <= next_track_cnt;
      tick_cnt    <= next_tick_cnt;
      sar_trial   <= next_sar_trial;
      result_raw  <= next_result_raw;
      result_diff <= next_result_diff;
      conv_diff   <= next_conv_diff;
      gap_cnt     <= next_gap_cnt;
    end
  end

  // ---------------------------------------------------------------------
  // Register file writes, flag and reads
  // ---------------------------------------------------------------------
  always_comb begin
    next_converter_enable     = converter_enable;
    next_track_mode_select    = track_mode_select;
    next_conversion_done_flag = conversion_done_flag;
    next_start_mode           = start_mode;
    next_result_left_justify  = result_left_justify;
    next_pair_config_reg      = pair_config_reg;
    next_channel_select_field = channel_select_field;
    next_clock_period_field   = clock_period_field;
    next_gain_select_field    = gain_select_field;
    if (sfr_wr) begin
      unique case (sfr_addr)
        ADDR_CONTROL: begin
          next_converter_enable     = sfr_wdata[CTL_EN];
          next_track_mode_select    = sfr_wdata[CTL_TM];
          next_conversion_done_flag = sfr_wdata[CTL_INT];
          next_start_mode           = sfr_wdata[CTL_STM_LO+1:CTL_STM_LO];
          next_result_left_justify  = sfr_wdata[CTL_LJST];
        end
        ADDR_PAIR_CFG: next_pair_config_reg = sfr_wdata[3:0];
        ADDR_CHAN_SEL: next_channel_select_field = sfr_wdata[3:0];
        ADDR_CONFIG: begin
          next_clock_period_field = sfr_wdata[CFG_SC_LO+2:CFG_SC_LO];
          next_gain_select_field  = sfr_wdata[CFG_GAIN_LO+2:CFG_GAIN_LO];
        end
        default: ;
      endcase
    end
    // Completion wins over a same-cycle software clear
    if (conv_done) begin
      next_conversion_done_flag = 1'b1;
    end
    next_conv_irq = next_conversion_done_flag && irq_enable;
    // Result word formed with the justify bit in force at read time
    if (result_left_justify) begin
      data_word = {result_raw, 6'h00};
    end else begin
      data_word = {{6{result_diff & result_raw[RES_BITS-1]}}, result_raw};
    end
    next_sfr_rdata = sfr_rdata;
    if (sfr_rd) begin
      unique case (sfr_addr)
        ADDR_CONTROL:  next_sfr_rdata = {converter_enable, track_mode_select,
                                         conversion_done_flag, busy,
                                         start_mode, 1'b0, result_left_justify};
        ADDR_PAIR_CFG: next_sfr_rdata = {4'h0, pair_config_reg};
        ADDR_CHAN_SEL: next_sfr_rdata = {4'h0, channel_select_field};
        ADDR_CONFIG:   next_sfr_rdata = {clock_period_field, 2'h0, gain_select_field};
        ADDR_RES_HIGH: next_sfr_rdata = data_word[15:8];
        ADDR_RES_LOW:  next_sfr_rdata = data_word[7:0];
        default:       next_sfr_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      converter_enable     <= 1'b0;
      track_mode_select    <= 1'b0;
      conversion_done_flag <= 1'b0;
      start_mode           <= STM_SOFT;
      result_left_justify  <= 1'b0;
      pair_config_reg      <= RST_PAIR_CFG;
      channel_select_field <= RST_CHAN_SEL;
      clock_period_field   <= RST_PERIOD;
      gain_select_field    <= RST_GAIN;
      sfr_rdata            <= 8'h00;
      conv_irq             <= 1'b0;
    end else begin
      converter_enable     <= next_converter_enable;
      track_mode_select    <= next_track_mode_select;
      conversion_done_flag <= next_conversion_done_flag;
      start_mode           <= next_start_mode;
      result_left_justify  <= next_result_left_justify;
      pair_config_reg      <= next_pair_config_reg;
      channel_select_field <= next_channel_select_field;
      clock_period_field   <= next_clock_period_field;
      gain_select_field    <= next_gain_select_field;
      sfr_rdata            <= next_sfr_rdata;
      conv_irq             <= next_conv_irq;
    end
  end

  // ---------------------------------------------------------------------
  // Analog front-end controls
  // ---------------------------------------------------------------------
  always_comb begin
    next_analog_enable = converter_enable;
    next_gain_select   = converter_enable ? gain_select_field : RST_GAIN;
    if (next_state == ADCC_IDLE) begin
      next_mux_differential = live_diff;
      next_mux_channel      = channel_select_field[CHAN_TEMP] ? MUX_TEMP :
                              (live_diff ? {1'b0, channel_select_field[2:1], 1'b0}
                                         : {1'b0, channel_select_field[2:0]});
    end else begin
      next_mux_differential = mux_differential;
      next_mux_channel      = mux_channel;
    end
    if (!converter_enable || chip_low_power) begin
      next_track_enable = 1'b0;
    end else if (!track_mode_select) begin
      next_track_enable = (next_state == ADCC_IDLE);
    end else if (start_mode == STM_EXT) begin
      next_track_enable = (next_state == ADCC_IDLE) && !ext_sync;
    end else begin
      next_track_enable = (next_state == ADCC_TRACK);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      analog_enable    <= 1'b0;
      track_enable     <= 1'b0;
      mux_channel      <= 4'h0;
      mux_differential <= 1'b0;
      gain_select      <= RST_GAIN;
    end else begin
      analog_enable    <= next_analog_enable;
      track_enable     <= next_track_enable;
      mux_channel      <= next_mux_channel;
      mux_differential <= next_mux_differential;
      gain_select      <= next_gain_select;
    end
  end

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  shutdown_off_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !converter_enable |=> !analog_enable && !track_enable && (state == ADCC_IDLE))
    else $error("analog active while disabled");

  conv_length_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (start_ok && !track_mode_select && clock_period_field == 3'h0 && converter_enable)
    |=> busy ##15 (busy && conv_done))
    else $error("undivided conversion not 16 clocks");

  done_flag_a: assert property (@(posedge core_clk) disable iff (!nrst)
    conv_done |=> conversion_done_flag && !busy && (conv_irq == $past(irq_enable)))
    else $error("done flag not set at busy fall");

  busy_read_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (sfr_rd && sfr_addr == ADDR_CONTROL) |=> (sfr_rdata[CTL_BUSY] == $past(busy)))
    else $error("busy bit misread");

  track_three_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state == ADCC_TRACK && sar_tick && track_cnt == TRACK_LAST_TICK && converter_enable)
    |=> (state == ADCC_CONV) && !track_enable)
    else $error("tracking window not 3 SAR clocks");

  ext_track_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (converter_enable && track_mode_select && start_mode == STM_EXT && ext_sync)
    |=> !track_enable)
    else $error("tracking while start input high");

  sleep_track_a: assert property (@(posedge core_clk) disable iff (!nrst)
    chip_low_power |=> !track_enable)
    else $error("tracking during low power");

  idle_track_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (converter_enable && !track_mode_select && !chip_low_power && next_state == ADCC_IDLE)
    |=> track_enable)
    else $error("not tracking while idle");

  left_just_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (sfr_rd && sfr_addr == ADDR_RES_LOW && result_left_justify) |=> sfr_rdata[5:0] == 6'h00)
    else $error("left justified low bits not zero");

  temp_mux_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (next_state == ADCC_IDLE && channel_select_field[CHAN_TEMP])
    |=> (mux_channel == MUX_TEMP) && !mux_differential)
    else $error("temperature channel not selected");

  rate_limit_a: assert property (@(posedge core_clk) disable iff (!nrst)
    start_ok |=> (gap_cnt == GAP_LOAD) && !start_ok)
    else $error("start spacing not enforced");

endmodule

//--- tb/adcc_analog_model.sv
// Comparator stand-in for the analog front end of the converter.
// Assumes sar_trial is offset binary and settles on the core clock.
`timescale 1ns/1ps
module adcc_analog_model #(
  parameter logic [9:0] LEVEL = 10'h155
) (
  input  wire logic [9:0] sar_trial,
  output logic            sar_cmp
);
  // Keep the trial bit while the trial does not exceed the input level
  assign sar_cmp = (sar_trial <= LEVEL);
endmodule

//--- tb/adcc_conversion_control_test.sv
// Self-checking bench for the converter control block.
// Assumes the comparator model and register access through the SFR port.
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module adcc_conversion_control_test import adcc_pkg::*;;
  typedef struct packed { logic [7:0] a; logic [7:0] d; logic [7:0] e; } adcc_row_t;
  logic       core_clk, nrst, sfr_wr, sfr_rd, timer3_overflow, timer2_overflow;
  logic       external_convert_start, chip_low_power, irq_enable, sar_cmp, conv_irq;
  logic       analog_enable, track_enable, mux_differential;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [3:0] mux_channel;
  logic [2:0] gain_select;
  logic [9:0] sar_trial;
  int         fail_count, tests_run;
  // Write, read-back value
  adcc_row_t  rows [4] = '{'{8'hBA, 8'hFF, 8'h0F}, '{8'hBB, 8'hFF, 8'h0F},
                           '{8'hBC, 8'hFF, 8'hE7}, '{8'h00, 8'h55, 8'h00}};
  adcc_conversion_control adcc_conversion_control_i (.core_clk, .nrst, .sfr_addr, .sfr_wr,
    .sfr_rd, .sfr_wdata, .sfr_rdata, .timer3_overflow, .timer2_overflow,
    .external_convert_start, .chip_low_power, .irq_enable, .sar_cmp, .conv_irq,
    .analog_enable, .track_enable, .mux_channel, .mux_differential, .gain_select, .sar_trial);
  adcc_analog_model adcc_analog_model_i (.sar_trial, .sar_cmp);
  // ----------------------------------------------------------------
  // Clock, bus tasks, verdict
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1 `CHK("sfr_rdata", e, sfr_rdata)
  endtask
  // One-cycle overflow pulse on timer 3 when sel is 1, else timer 2
  task automatic pulse(input logic sel);
    @(posedge core_clk);
    timer3_overflow <= sel;
    timer2_overflow <= !sel;
    @(posedge core_clk);
    timer3_overflow <= 1'b0;
    timer2_overflow <= 1'b0;
  endtask
  task automatic close_out;
    if (fail_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    close_out();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {sfr_wr, sfr_rd, timer3_overflow, timer2_overflow} = 4'h0;
    {external_convert_start, chip_low_power, sfr_addr, sfr_wdata} = 18'h0;
    irq_enable = 1'b1;
    nrst = 1'b0;
    fail_count = 0;
    tests_run = 0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    // Second reset restores defaults
    nrst <= 1'b0;
    @(posedge core_clk);
    nrst <= 1'b1;
    rd(8'hBA, 8'h00);
    rd(8'hBC, 8'h60);
    rd(8'hE8, 8'h00);
    // Undivided software conversion, single-ended
    wr(8'hBC, 8'h00);
    wr(8'hE8, 8'h80);
    @(posedge core_clk);
    #1 `CHK("analog_enable", 1'b1, analog_enable)
    wr(8'hE8, 8'h90);
    repeat (15) @(posedge core_clk);
    #1 `CHK("conv_irq", 1'b0, conv_irq)
    `CHK("track_enable", 1'b0, track_enable)
    repeat (3) @(posedge core_clk);
    #1 `CHK("conv_irq", 1'b1, conv_irq)
    `CHK("sar_trial", 10'h155, sar_trial)
    `CHK("track_enable", 1'b1, track_enable)
    rd(8'hE8, 8'hA0);
    rd(8'hBF, 8'h01);
    rd(8'hBE, 8'h55);
    // Early trigger is dropped, then a differential left-justified one
    wr(8'hE8, 8'h91);
    rd(8'hE8, 8'h81);
    wr(8'hBA, 8'h01);
    repeat (400) @(posedge core_clk);
    wr(8'hE8, 8'h91);
    rd(8'hE8, 8'h91);
    `CHK("mux_differential", 1'b1, mux_differential)
    repeat (20) @(posedge core_clk);
    rd(8'hBF, 8'hD5);
    rd(8'hBE, 8'h40);
    // Gain and temperature channel, interrupt masked from here on
    wr(8'hBC, 8'h03);
    wr(8'hBB, 8'h0B);
    irq_enable <= 1'b0;
    @(posedge core_clk);
    #1 `CHK("gain_select", 3'h3, gain_select)
    `CHK("mux_channel", 4'h8, mux_channel)
    `CHK("mux_differential", 1'b0, mux_differential)
    // Timer modes: the other timer is ignored, the chosen one starts
    for (int m = 1; m < 4; m += 2) begin
      wr(8'hE8, 8'h80 | 8'(m << 2));
      repeat (400) @(posedge core_clk);
      pulse(m == 3);
      rd(8'hE8, 8'h80 | 8'(m << 2));
      pulse(m == 1);
      rd(8'hE8, 8'h90 | 8'(m << 2));
      repeat (20) @(posedge core_clk);
    end
    #1 `CHK("conv_irq", 1'b0, conv_irq)
    // Low-power tracking: three SAR clocks after a software start
    wr(8'hE8, 8'hC0);
    repeat (400) @(posedge core_clk);
    wr(8'hE8, 8'hD0);
    repeat (2) @(posedge core_clk);
    #1 `CHK("track_enable", 1'b1, track_enable)
    @(posedge core_clk);
    #1 `CHK("track_enable", 1'b0, track_enable)
    // External start: track while low, start on the rising edge
    repeat (400) @(posedge core_clk);
    wr(8'hE8, 8'hC8);
    @(posedge core_clk);
    #1 `CHK("track_enable", 1'b1, track_enable)
    external_convert_start <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 `CHK("track_enable", 1'b0, track_enable)
    rd(8'hE8, 8'hD8);
    // Chip standby stops tracking even in continuous mode
    repeat (20) @(posedge core_clk);
    chip_low_power <= 1'b1;
    wr(8'hE8, 8'h80);
    @(posedge core_clk);
    #1 `CHK("track_enable", 1'b0, track_enable)
    close_out();
  end
endmodule
